/* design/cfg56_pkg.sv */
// Package of frame layout, codes and timing constants for the channel 5/6 configuration block
package cfg56_pkg;
  localparam int CLK_MHZ = 25;
  localparam logic [3:0] CMD_CH5 = 4'h5;
  localparam logic [3:0] CMD_CH6 = 4'h6;
  localparam int CMD_MSB = 31;
  localparam int CMD_LSB = 28;
  localparam int RW_BIT = 27;
  localparam int TOFF_MSB = 26;
  localparam int TOFF_LSB = 25;
  localparam int FIXED_BIT = 24;
  localparam int TDIAG_MSB = 23;
  localparam int TDIAG_LSB = 22;
  localparam int RDSEL_BIT = 21;
  localparam int THR_MSB = 20;
  localparam int THR_LSB = 15;
  localparam int TCOMP_MSB = 14;
  localparam int TCOMP_LSB = 13;
  localparam int BCOMP_BIT = 12;
  localparam int BLANK_MSB = 11;
  localparam int BLANK_LSB = 9;
  localparam int REENG_BIT = 8;
  localparam int SENSE_BIT = 7;
  localparam int OLCUR_BIT = 6;
  localparam int GATE_MSB = 5;
  localparam int GATE_LSB = 4;
  localparam int NP_BIT = 3;
  localparam int SIDE_BIT = 2;
  localparam int EN_BIT = 1;
  localparam int PAR_BIT = 0;
  localparam logic [26:0] CFG_RESET = 27'h0000000;
  // Filter times in tenths of a microsecond
  localparam int BR_TDIAG_0 = 112;
  localparam int BR_TDIAG_1 = 289;
  localparam int BR_TDIAG_2 = 400;
  localparam int BR_TDIAG_3 = 512;
  localparam int CH_TDIAG_0 = 256;
  localparam int CH_TDIAG_1 = 612;
  localparam int CH_TDIAG_2 = 1056;
  localparam int CH_TDIAG_3 = 1500;
  // Blanking times in tenths of a microsecond
  localparam int BLANK_0 = 111;
  localparam int BLANK_1 = 156;
  localparam int BLANK_2 = 200;
  localparam int BLANK_3 = 311;
  localparam int BLANK_4 = 422;
  localparam int BLANK_5 = 533;
  localparam int BLANK_6 = 978;
  localparam int BLANK_7 = 1422;
  // Off times in tenths of a microsecond
  localparam int TOFF_0 = 310;
  localparam int TOFF_1 = 480;
  localparam int TOFF_2 = 625;
  localparam int TOFF_3 = 1250;
  // Least times round up to whole cycles
  function automatic logic [15:0] cyc(input int tenths_us);
    cyc = 16'((tenths_us * CLK_MHZ + 9) / 10);
  endfunction
  typedef enum logic [1:0] {CFG56_IDLE, CFG56_TRIP, CFG56_ARMED} cfg56_prot_t;
endpackage

/* design/cfg56_chan.sv */
// One channel's overcurrent protection and re-engagement sequencer
`timescale 1ns/10ps
`default_nettype none
module cfg56_chan (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic output_enable,
  input wire logic reengage_strategy,
  input wire logic bridge_mode,
  input wire logic overcurrent_event,
  input wire logic diag_readout,
  input wire logic diag_clear,
  input wire logic control_in,
  output logic drive_allowed
);
  typedef struct packed {
    cfg56_pkg::cfg56_prot_t st;
    logic ctl_d;
  } cfg56_chan_t;
  cfg56_chan_t s_r, s_nxt;
  logic edge_seen;
  logic need_readout;

  always_comb begin
    s_nxt = s_r;
    s_nxt.ctl_d = control_in;
    edge_seen = control_in != s_r.ctl_d;
    need_readout = reengage_strategy | bridge_mode; // RULE10
    case (s_r.st)
      cfg56_pkg::CFG56_IDLE: begin
        if (overcurrent_event) begin
          s_nxt.st = need_readout ? cfg56_pkg::CFG56_TRIP : cfg56_pkg::CFG56_ARMED; // RULE9
        end
      end
      cfg56_pkg::CFG56_TRIP: begin
        // Bridge waits for latch clear, single channel for a readout
        if (bridge_mode ? diag_clear : diag_readout) begin // RULE10
          s_nxt.st = cfg56_pkg::CFG56_ARMED;
        end
      end
      cfg56_pkg::CFG56_ARMED: begin
        if (edge_seen) begin
          s_nxt.st = cfg56_pkg::CFG56_IDLE; // RULE9
        end
      end
      default: s_nxt.st = cfg56_pkg::CFG56_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
      drive_allowed <= 1'b0;
    end else begin
      s_r <= s_nxt;
      drive_allowed <= output_enable && (s_nxt.st == cfg56_pkg::CFG56_IDLE);
    end
  end

  a_trip_blocks: assert property (@(posedge clk) disable iff (!rst_n)
    overcurrent_event && s_r.st == cfg56_pkg::CFG56_IDLE |=> !drive_allowed) // RULE9
    else $error("drive not removed after overcurrent");
  a_bridge_waits: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.st == cfg56_pkg::CFG56_TRIP && bridge_mode && !diag_clear |=> s_r.st == cfg56_pkg::CFG56_TRIP) // RULE10
    else $error("bridge left trip without latch clear");
  a_single_restart: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.st == cfg56_pkg::CFG56_IDLE && overcurrent_event && !reengage_strategy && !bridge_mode
    |=> s_r.st == cfg56_pkg::CFG56_ARMED) // RULE9
    else $error("strategy 0 did not arm directly");
  c_trip: cover property (@(posedge clk) disable iff (!rst_n) s_r.st == cfg56_pkg::CFG56_TRIP ##[1:20]
    s_r.st == cfg56_pkg::CFG56_IDLE);
endmodule
`default_nettype wire

/* design/cfg56_frames.sv */
// Decoder and holder of the channel 5 and channel 6 configuration frames
//
// Behaviour
// (RULE1) Bridge on, extension 0: ch5 timer code picks 11.2/28.9/40/51.2 us bridge filter.
// (RULE2) Otherwise ch5 timer code picks 25.6/61.2/105.6/150 us; also used with extension 1.
// (RULE3) Ch6 timer picks same four times; ignored when bridge on with extension 0.
// (RULE4) Readback select returns fixed threshold at 0, compensated threshold at 1.
// (RULE5) Bits 20:15 hold the six-bit overcurrent threshold index per channel.
// (RULE6) Two-bit temperature compensation: none, or below 60, 40, 25 degrees.
// (RULE7) Bit 12 switches battery compensation on or off.
// (RULE8) Three-bit blanking code selects 11.1 to 142.2 us detection mask.
// (RULE9) Re-engage bit 0 restarts on switching edge; 1 needs readout first.
// (RULE10) Bridge mode always behaves as re-engage 1, waiting for latch clear.
// (RULE11) Bit 7 selects drain-source monitoring at 0, shunt at 1.
// (RULE12) Bit 6 selects open-load current 100 uA or 1 mA.
// (RULE13) Gate current: resistor limited, 20 mA, 5 mA or 1 mA.
// (RULE14) Bit 3 selects NMOS at 0, PMOS at 1.
// (RULE15) Bit 2 low or high side; bit 1 output disable or enable.
// (RULE16) Bit 0 is even parity over the other bits, generated and checked; the code sets bit 0 so a good frame has odd weight.
// (RULE17) Host puts command 0110 in the top nibble for channel 6.
// (RULE18) Bit 27 at 0 writes and reads back, at 1 reads only.
// (RULE19) Ch6 bits 26:25 set bridge limit off time 31/48/62.5/125 us.
// (RULE20) Ch6 bit 24 must be 0; otherwise the frame is invalid.
// (RULE21) Bridge enable groups channels 5 to 8 into the second bridge.
// (RULE22) Extension 0 spreads ch5 timer to channels 6-8; 1 keeps each own.
`timescale 1ns/10ps
`default_nettype none
module cfg56_frames (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic frame_valid,
  input wire logic [31:0] frame_in,
  input wire logic bridge2_enable,
  input wire logic bridge2_timer_extension_sel,
  input wire logic [5:0] ch5_comp_threshold,
  input wire logic [5:0] ch6_comp_threshold,
  input wire logic [1:0] overcurrent_event,
  input wire logic [1:0] diag_readout,
  input wire logic diag_clear,
  input wire logic [1:0] control_in,
  output logic reply_valid,
  output logic [31:0] reply_frame,
  output logic frame_error,
  output logic [15:0] ch5_tdiag_cycles,
  output logic [15:0] ch6_tdiag_cycles,
  output logic [15:0] ch5_blank_cycles,
  output logic [15:0] ch6_blank_cycles,
  output logic [15:0] bridge2_limit_off_timer,
  output logic [5:0] ch5_overcurrent_threshold,
  output logic [5:0] ch6_overcurrent_threshold,
  output logic [1:0] ch5_temperature_comp,
  output logic [1:0] ch6_temperature_comp,
  output logic [1:0] battery_comp,
  output logic [1:0] sense_method,
  output logic [1:0] open_load_current_high,
  output logic [1:0] ch5_gate_current_sel,
  output logic [1:0] ch6_gate_current_sel,
  output logic [1:0] pmos_select,
  output logic [1:0] side_select,
  output logic [1:0] drive_allowed
);
  typedef struct packed {
    logic [26:0] ch5;
    logic [26:0] ch6;
    logic rvalid;
    logic [31:0] reply;
    logic err;
    logic [15:0] t5;
    logic [15:0] t6;
    logic [15:0] b5;
    logic [15:0] b6;
    logic [15:0] toff;
  } cfg56_state_t;
  cfg56_state_t s_r, s_nxt;
  logic [3:0] cmd;
  logic par_ok;
  logic is5, is6;
  logic bridge_timer;
  logic [26:0] body;
  logic [30:0] rb;
  logic [1:0] drv;

  function automatic logic [15:0] ch_tdiag(input logic [1:0] code);
    case (code)
      2'h0: ch_tdiag = cfg56_pkg::cyc(cfg56_pkg::CH_TDIAG_0);
      2'h1: ch_tdiag = cfg56_pkg::cyc(cfg56_pkg::CH_TDIAG_1);
      2'h2: ch_tdiag = cfg56_pkg::cyc(cfg56_pkg::CH_TDIAG_2);
      default: ch_tdiag = cfg56_pkg::cyc(cfg56_pkg::CH_TDIAG_3);
    endcase
  endfunction

  function automatic logic [15:0] br_tdiag(input logic [1:0] code);
    case (code)
      2'h0: br_tdiag = cfg56_pkg::cyc(cfg56_pkg::BR_TDIAG_0);
      2'h1: br_tdiag = cfg56_pkg::cyc(cfg56_pkg::BR_TDIAG_1);
      2'h2: br_tdiag = cfg56_pkg::cyc(cfg56_pkg::BR_TDIAG_2);
      default: br_tdiag = cfg56_pkg::cyc(cfg56_pkg::BR_TDIAG_3);
    endcase
  endfunction

  function automatic logic [15:0] blank(input logic [2:0] code);
    case (code)
      3'h0: blank = cfg56_pkg::cyc(cfg56_pkg::BLANK_0);
      3'h1: blank = cfg56_pkg::cyc(cfg56_pkg::BLANK_1);
      3'h2: blank = cfg56_pkg::cyc(cfg56_pkg::BLANK_2);
      3'h3: blank = cfg56_pkg::cyc(cfg56_pkg::BLANK_3);
      3'h4: blank = cfg56_pkg::cyc(cfg56_pkg::BLANK_4);
      3'h5: blank = cfg56_pkg::cyc(cfg56_pkg::BLANK_5);
      3'h6: blank = cfg56_pkg::cyc(cfg56_pkg::BLANK_6);
      default: blank = cfg56_pkg::cyc(cfg56_pkg::BLANK_7);
    endcase
  endfunction

  function automatic logic [15:0] toff(input logic [1:0] code);
    case (code)
      2'h0: toff = cfg56_pkg::cyc(cfg56_pkg::TOFF_0);
      2'h1: toff = cfg56_pkg::cyc(cfg56_pkg::TOFF_1);
      2'h2: toff = cfg56_pkg::cyc(cfg56_pkg::TOFF_2);
      default: toff = cfg56_pkg::cyc(cfg56_pkg::TOFF_3);
    endcase
  endfunction

  always_comb begin
    s_nxt = s_r;
    cmd = frame_in[cfg56_pkg::CMD_MSB:cfg56_pkg::CMD_LSB];
    // Bit 0 is set for an even count elsewhere, so a good frame has odd weight
    par_ok = ^frame_in; // RULE16
    is5 = cmd == cfg56_pkg::CMD_CH5;
    is6 = cmd == cfg56_pkg::CMD_CH6; // RULE17
    body = frame_in[26:0];
    rb = '0;
    s_nxt.rvalid = 1'b0;
    s_nxt.err = 1'b0;
    if (frame_valid && (is5 || is6)) begin
      if (!par_ok || (is6 && frame_in[cfg56_pkg::FIXED_BIT])) begin
        s_nxt.err = 1'b1; // RULE16 RULE20
      end else begin
        if (!frame_in[cfg56_pkg::RW_BIT]) begin // RULE18
          if (is5) begin
            s_nxt.ch5 = body;
          end else begin
            s_nxt.ch6 = body;
          end
        end
        rb[30:27] = cmd;
        rb[26:0] = is5 ? s_nxt.ch5 : s_nxt.ch6;
        // Readback shows fixed or compensated threshold
        if (rb[cfg56_pkg::RDSEL_BIT]) begin // RULE4
          rb[cfg56_pkg::THR_MSB:cfg56_pkg::THR_LSB] = is5 ? ch5_comp_threshold : ch6_comp_threshold;
        end
        s_nxt.rvalid = 1'b1;
        s_nxt.reply = {1'b0, rb[30:1], ~^rb[30:1]}; // RULE16
      end
    end
    // Bridge filter applies only to grouped channels with shared timer
    bridge_timer = bridge2_enable && !bridge2_timer_extension_sel; // RULE21 RULE22
    s_nxt.t5 = bridge_timer ? br_tdiag(s_nxt.ch5[cfg56_pkg::TDIAG_MSB:cfg56_pkg::TDIAG_LSB]) // RULE1
      : ch_tdiag(s_nxt.ch5[cfg56_pkg::TDIAG_MSB:cfg56_pkg::TDIAG_LSB]); // RULE2
    s_nxt.t6 = bridge_timer ? s_nxt.t5 // RULE3
      : ch_tdiag(s_nxt.ch6[cfg56_pkg::TDIAG_MSB:cfg56_pkg::TDIAG_LSB]);
    s_nxt.b5 = blank(s_nxt.ch5[cfg56_pkg::BLANK_MSB:cfg56_pkg::BLANK_LSB]); // RULE8
    s_nxt.b6 = blank(s_nxt.ch6[cfg56_pkg::BLANK_MSB:cfg56_pkg::BLANK_LSB]); // RULE8
    s_nxt.toff = toff(s_nxt.ch6[cfg56_pkg::TOFF_MSB:cfg56_pkg::TOFF_LSB]); // RULE19
  end

  cfg56_chan u_ch5 (
    .clk(clk),
    .rst_n(rst_n),
    .output_enable(s_r.ch5[cfg56_pkg::EN_BIT]),
    .reengage_strategy(s_r.ch5[cfg56_pkg::REENG_BIT]),
    .bridge_mode(bridge2_enable),
    .overcurrent_event(overcurrent_event[0]),
    .diag_readout(diag_readout[0]),
    .diag_clear(diag_clear),
    .control_in(control_in[0]),
    .drive_allowed(drv[0])
  );

  cfg56_chan u_ch6 (
    .clk(clk),
    .rst_n(rst_n),
    .output_enable(s_r.ch6[cfg56_pkg::EN_BIT]),
    .reengage_strategy(s_r.ch6[cfg56_pkg::REENG_BIT]),
    .bridge_mode(bridge2_enable),
    .overcurrent_event(overcurrent_event[1]),
    .diag_readout(diag_readout[1]),
    .diag_clear(diag_clear),
    .control_in(control_in[1]),
    .drive_allowed(drv[1])
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.ch5 <= cfg56_pkg::CFG_RESET;
      s_r.ch6 <= cfg56_pkg::CFG_RESET;
      s_r.t5 <= cfg56_pkg::cyc(cfg56_pkg::CH_TDIAG_0);
      s_r.t6 <= cfg56_pkg::cyc(cfg56_pkg::CH_TDIAG_0);
      s_r.b5 <= cfg56_pkg::cyc(cfg56_pkg::BLANK_0);
      s_r.b6 <= cfg56_pkg::cyc(cfg56_pkg::BLANK_0);
      s_r.toff <= cfg56_pkg::cyc(cfg56_pkg::TOFF_0);
    end else begin
      s_r <= s_nxt;
    end
  end

  // Field outputs are straight register bits
  assign reply_valid = s_r.rvalid;
  assign reply_frame = s_r.reply;
  assign frame_error = s_r.err;
  assign ch5_tdiag_cycles = s_r.t5;
  assign ch6_tdiag_cycles = s_r.t6;
  assign ch5_blank_cycles = s_r.b5;
  assign ch6_blank_cycles = s_r.b6;
  assign bridge2_limit_off_timer = s_r.toff;
  assign ch5_overcurrent_threshold = s_r.ch5[cfg56_pkg::THR_MSB:cfg56_pkg::THR_LSB]; // RULE5
  assign ch6_overcurrent_threshold = s_r.ch6[cfg56_pkg::THR_MSB:cfg56_pkg::THR_LSB]; // RULE5
  assign ch5_temperature_comp = s_r.ch5[cfg56_pkg::TCOMP_MSB:cfg56_pkg::TCOMP_LSB]; // RULE6
  assign ch6_temperature_comp = s_r.ch6[cfg56_pkg::TCOMP_MSB:cfg56_pkg::TCOMP_LSB]; // RULE6
  assign battery_comp = {s_r.ch6[cfg56_pkg::BCOMP_BIT], s_r.ch5[cfg56_pkg::BCOMP_BIT]}; // RULE7
  assign sense_method = {s_r.ch6[cfg56_pkg::SENSE_BIT], s_r.ch5[cfg56_pkg::SENSE_BIT]}; // RULE11
  assign open_load_current_high = {s_r.ch6[cfg56_pkg::OLCUR_BIT], s_r.ch5[cfg56_pkg::OLCUR_BIT]}; // RULE12
  assign ch5_gate_current_sel = s_r.ch5[cfg56_pkg::GATE_MSB:cfg56_pkg::GATE_LSB]; // RULE13
  assign ch6_gate_current_sel = s_r.ch6[cfg56_pkg::GATE_MSB:cfg56_pkg::GATE_LSB]; // RULE13
  assign pmos_select = {s_r.ch6[cfg56_pkg::NP_BIT], s_r.ch5[cfg56_pkg::NP_BIT]}; // RULE14
  assign side_select = {s_r.ch6[cfg56_pkg::SIDE_BIT], s_r.ch5[cfg56_pkg::SIDE_BIT]}; // RULE15
  assign drive_allowed = drv; // RULE15

  a_reply_parity: assert property (@(posedge clk) disable iff (!rst_n)
    reply_valid |-> reply_frame[0] == ~^reply_frame[31:1]) // RULE16
    else $error("reply parity wrong");
  a_bad_parity: assert property (@(posedge clk) disable iff (!rst_n)
    frame_valid && (is5 || is6) && !par_ok |=> frame_error && !reply_valid) // RULE16
    else $error("bad parity frame not flagged");
  a_read_only: assert property (@(posedge clk) disable iff (!rst_n)
    frame_valid && frame_in[cfg56_pkg::RW_BIT] |=> $stable(s_r.ch5) && $stable(s_r.ch6)) // RULE18
    else $error("read only frame changed configuration");
  a_fixed_bit: assert property (@(posedge clk) disable iff (!rst_n)
    frame_valid && is6 && frame_in[cfg56_pkg::FIXED_BIT] |=> frame_error && $stable(s_r.ch6)) // RULE20
    else $error("fixed pattern violation accepted");
  a_bridge_tdiag: assert property (@(posedge clk) disable iff (!rst_n)
    bridge2_enable && !bridge2_timer_extension_sel && s_r.ch5[23:22] == 2'h0 ##1
    $stable(bridge2_enable) && $stable(bridge2_timer_extension_sel) && $stable(s_r.ch5)
    |-> ch5_tdiag_cycles == 16'd280 && ch6_tdiag_cycles == 16'd280) // RULE1 RULE3
    else $error("bridge filter time wrong");
  a_own_tdiag: assert property (@(posedge clk) disable iff (!rst_n)
    !bridge2_enable && s_r.ch6[23:22] == 2'h3 ##1 !bridge2_enable && $stable(s_r.ch6)
    |-> ch6_tdiag_cycles == 16'd3750) // RULE2 RULE3
    else $error("channel filter time wrong");
  a_blank_max: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.ch5[11:9] == 3'h7 ##1 $stable(s_r.ch5) |-> ch5_blank_cycles == 16'd3555) // RULE8
    else $error("blanking time wrong");
  a_toff_time: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.ch6[26:25] == 2'h2 ##1 $stable(s_r.ch6) |-> bridge2_limit_off_timer == 16'd1563) // RULE19
    else $error("off timer wrong");
  a_write_stores: assert property (@(posedge clk) disable iff (!rst_n)
    frame_valid && is5 && par_ok && !frame_in[cfg56_pkg::RW_BIT] |=> ch5_overcurrent_threshold == $past(frame_in[20:15])) // RULE5
    else $error("threshold not stored");
  c_write6: cover property (@(posedge clk) disable iff (!rst_n) frame_valid && is6 ##1 reply_valid);
  c_read5: cover property (@(posedge clk) disable iff (!rst_n) frame_valid && is5 && frame_in[27] ##1 reply_valid);
  c_error: cover property (@(posedge clk) disable iff (!rst_n) frame_error);
  c_bridge: cover property (@(posedge clk) disable iff (!rst_n) bridge2_enable && drive_allowed == 2'h0);
endmodule
`default_nettype wire

/* verification/cfg56_host_model.sv */
// Host stand-in that hands whole configuration frames to the block
`timescale 1ns/10ps
`default_nettype none
module cfg56_host_model (
  input wire logic clk,
  output logic frame_valid,
  output logic [31:0] frame_in
);
  initial begin
    frame_valid = 1'b0;
    frame_in = 32'h00000000;
  end
  // Parity is spoiled only when a scenario asks for a bad frame
  task automatic send(input logic [3:0] cmd, input logic rw, input logic [26:0] body, input logic bad);
    logic [31:0] f;
    f = {cmd, rw, body};
    f[0] = (~^f[31:1]) ^ bad;
    @(posedge clk);
    frame_valid <= 1'b1;
    frame_in <= f;
    @(posedge clk);
    frame_valid <= 1'b0;
    // Released bus must not keep showing the old frame
    frame_in <= ~f;
  endtask
endmodule
`default_nettype wire

/* verification/cfg56_frames_test.sv */
// Self-checking bench for the channel 5/6 configuration frame block
`timescale 1ns/10ps
`default_nettype none
module cfg56_frames_test;
  localparam logic [26:0] B1 = 27'h096FBEC;
  localparam logic [26:0] B2 = 27'h4492412;
  logic clk, rst_n, fv, b2en, b2ext, clr, rv, fe;
  logic [31:0] fin, rf;
  logic [5:0] c5thr, c6thr, t5, t6;
  logic [1:0] oc, rd, ctl, tc5, tc6, bc, sm, olh, g5, g6, pm, sd, da;
  logic [15:0] td5, td6, bk5, bk6, toff;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  int ct[4] = '{256, 612, 1056, 1500};
  int bt[4] = '{112, 289, 400, 512};
  int tf[4] = '{310, 480, 625, 1250};
  int bl[8] = '{111, 156, 200, 311, 422, 533, 978, 1422};
  cfg56_frames dut (.clk(clk), .rst_n(rst_n), .frame_valid(fv), .frame_in(fin), .bridge2_enable(b2en),
    .bridge2_timer_extension_sel(b2ext), .ch5_comp_threshold(c5thr), .ch6_comp_threshold(c6thr),
    .overcurrent_event(oc), .diag_readout(rd), .diag_clear(clr), .control_in(ctl), .reply_valid(rv),
    .reply_frame(rf), .frame_error(fe), .ch5_tdiag_cycles(td5), .ch6_tdiag_cycles(td6),
    .ch5_blank_cycles(bk5), .ch6_blank_cycles(bk6), .bridge2_limit_off_timer(toff),
    .ch5_overcurrent_threshold(t5), .ch6_overcurrent_threshold(t6), .ch5_temperature_comp(tc5),
    .ch6_temperature_comp(tc6), .battery_comp(bc), .sense_method(sm), .open_load_current_high(olh),
    .ch5_gate_current_sel(g5), .ch6_gate_current_sel(g6), .pmos_select(pm), .side_select(sd),
    .drive_allowed(da));
  cfg56_host_model host (.clk(clk), .frame_valid(fv), .frame_in(fin));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] cy(input int t);
    cy = 16'((t * 25 + 9) / 10);
  endfunction
  task automatic fields(input int c, input logic [26:0] b);
    if (c == 5) begin
      chk(t5, b[20:15]);
      chk(tc5, b[14:13]);
      chk(g5, b[5:4]);
    end else begin
      chk(t6, b[20:15]);
      chk(tc6, b[14:13]);
      chk(g6, b[5:4]);
    end
    chk(bc[c-5], b[12]);
    chk(sm[c-5], b[7]);
    chk(olh[c-5], b[6]);
    chk(pm[c-5], b[3]);
    chk(sd[c-5], b[2]);
  endtask
  // Returns one edge after the reply so derived times have landed
  task automatic wr(input logic [3:0] cmd, input logic rw, input logic [26:0] b, input logic bad,
    input logic [26:0] e);
    logic err;
    err = bad | (cmd == 4'h6 && b[24]);
    host.send(cmd, rw, b, bad);
    #1;
    chk(fe, err);
    chk(rv, !err);
    if (!err) begin
      chk(rf[26:1], e[26:1]);
      chk(rf[31:27], {1'b0, cmd});
      chk(rf[0], ~^rf[31:1]);
    end
    @(posedge clk);
    #1;
  endtask
  task automatic ev(input logic [1:0] o, input logic [1:0] r, input logic c, input logic [1:0] t,
    input logic [1:0] exp);
    @(posedge clk);
    oc <= o;
    rd <= r;
    clr <= c;
    @(posedge clk);
    oc <= 2'h0;
    rd <= 2'h0;
    clr <= 1'b0;
    ctl <= ctl ^ t;
    repeat (4) @(posedge clk);
    #1;
    chk(da, exp);
  endtask
  initial begin
    logic [26:0] b, c, e, f;
    logic [2:0] k;
    rst_n = 1'b0;
    b2en = 1'b0;
    b2ext = 1'b0;
    clr = 1'b0;
    oc = 2'h0;
    rd = 2'h0;
    ctl = 2'h0;
    c5thr = 6'h11;
    c6thr = 6'h2A;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(td5, 16'h0280);
    chk(bk5, cy(111));
    chk(toff, cy(310));
    chk(da, 2'h0);
    wr(4'h5, 1'b0, B1, 1'b0, B1);
    wr(4'h6, 1'b0, B2, 1'b0, B2);
    fields(5, B1);
    fields(6, B2);
    b = B1 | 27'h0200000;
    e = b;
    e[20:15] = c5thr;
    wr(4'h5, 1'b0, b, 1'b0, e);
    c = B2 | 27'h0200000;
    f = c;
    f[20:15] = c6thr;
    wr(4'h6, 1'b0, c, 1'b0, f);
    wr(4'h5, 1'b1, 27'h0000000, 1'b0, e);
    fields(5, b);
    wr(4'h5, 1'b0, 27'h0000002, 1'b1, e);
    fields(5, b);
    wr(4'h6, 1'b0, B2 | 27'h1000000, 1'b0, f);
    fields(6, c);
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      b = 27'h0000000;
      b[23:22] = k[1:0];
      b[11:9] = k;
      c = 27'h0000000;
      c[26:25] = k[1:0];
      c[23:22] = ~k[1:0];
      c[11:9] = ~k;
      wr(4'h5, 1'b0, b, 1'b0, b);
      wr(4'h6, 1'b0, c, 1'b0, c);
      chk(td5, cy(ct[i%4]));
      chk(td6, cy(ct[3-i%4]));
      chk(bk5, cy(bl[i]));
      chk(bk6, cy(bl[7-i]));
      chk(toff, cy(tf[i%4]));
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      b2en <= 1'b1;
      b2ext <= 1'b0;
      k = 3'(i);
      b = 27'h0000000;
      b[23:22] = k[1:0];
      c = 27'h0000000;
      c[23:22] = ~k[1:0];
      wr(4'h5, 1'b0, b, 1'b0, b);
      wr(4'h6, 1'b0, c, 1'b0, c);
      chk(td5, cy(bt[i]));
      chk(td6, cy(bt[i]));
      @(posedge clk);
      b2ext <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk(td6, cy(ct[3-i]));
    end
    @(posedge clk);
    b2en <= 1'b0;
    wr(4'h5, 1'b0, 27'h0000002, 1'b0, 27'h0000002);
    wr(4'h6, 1'b0, 27'h0000102, 1'b0, 27'h0000102);
    chk(da, 2'h3);
    ev(2'h3, 2'h0, 1'b0, 2'h0, 2'h0);
    ev(2'h0, 2'h0, 1'b0, 2'h3, 2'h1);
    ev(2'h0, 2'h2, 1'b0, 2'h2, 2'h3);
    @(posedge clk);
    b2en <= 1'b1;
    ev(2'h1, 2'h0, 1'b0, 2'h0, 2'h2);
    ev(2'h0, 2'h0, 1'b0, 2'h1, 2'h2);
    ev(2'h0, 2'h0, 1'b1, 2'h1, 2'h3);
    wr(4'h5, 1'b0, 27'h0000000, 1'b0, 27'h0000000);
    chk(da, 2'h2);
    stop_test();
  end
endmodule
`default_nettype wire
